// ### src/lpt_pkg.sv
// package: constants, register map and types of the low-power timer front end
package lpt_pkg;
  localparam int CNT_W = 16;
  localparam int PSC_W = 3;
  // register indices on the plain port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CFG = 4'h1;
  localparam logic [3:0] REG_ARR = 4'h2;
  localparam logic [3:0] REG_CMP = 4'h3;
  localparam logic [3:0] REG_CNT = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h5;
  localparam logic [3:0] REG_MASK = 4'h6;
  // cfg field positions
  localparam int CFG_CLOCK_SOURCE_SELECT = 0;
  localparam int CFG_MODE = 1;
  localparam int CFG_POL = 2;
  localparam int CFG_PSC = 4;
  localparam int CFG_TSEL = 7;
  localparam int CFG_TEN = 10;
  localparam int CFG_IN1S = 11;
  localparam int CFG_IN2S = 12;
  localparam int CFG_WPOL = 13;
  localparam int CFG_KSRC = 14;
  // status bits
  localparam int ST_CMPM = 0;
  localparam int ST_ARRM = 1;
  localparam int ST_W = 2;
  localparam logic [CNT_W-1:0] ARR_RST = 16'hffff;
  localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
  localparam logic [1:0] EN_DLY = 2'h2;
  localparam logic [1:0] DIS_DLY = 2'h3;
  localparam logic [2:0] EXT_DROP = 3'h4;
  typedef enum logic [1:0] {
    LPT_POL_RISE = 2'b00,
    LPT_POL_FALL = 2'b01,
    LPT_POL_BOTH = 2'b10
  } lpt_pol_t;
  typedef enum logic [1:0] {
    LPT_ST_OFF = 2'b00,
    LPT_ST_ARM = 2'b01,
    LPT_ST_RUN = 2'b10,
    LPT_ST_STOP = 2'b11
  } lpt_state_t;
endpackage

// ### src/lpt_tick_if.sv
// interface: count ticks from the input front end to the counter
`timescale 1ns/10ps
interface lpt_tick_if;
  logic tick;
  logic in1_lvl;
  logic trig_lvl;
  modport src (output tick, output in1_lvl, output trig_lvl);
  modport dst (input tick, input in1_lvl, input trig_lvl);
endinterface

// ### src/lpt_input_front.sv
// input muxes, synchronisers and edge detection of the timer front end
`timescale 1ns/10ps
module lpt_input_front
  import lpt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // config
  input wire logic cfg_mode,
  input wire logic [1:0] cfg_pol,
  input wire logic in1_sel,
  input wire logic in2_sel,
  input wire logic [2:0] trig_sel,
  // raw inputs
  input wire logic in1_pin,
  input wire logic in2_pin,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  input wire logic [7:0] trig_raw,
  // to counter
  lpt_tick_if.src tk
);
  import lpt_pkg::*;
  logic [1:0] s1_r, s2_r, s3_r;
  logic [1:0] s1_nxt, s2_nxt, s3_nxt;
  logic [1:0] raw;
  logic rise, fall, tick_c;
  assign raw[0] = in1_sel ? cmp1_out : in1_pin;
  assign raw[1] = trig_raw[trig_sel];
  // in2 unused by counting here; it is muxed but cancels out of the tick
  logic in2_mux;
  assign in2_mux = in2_sel ? cmp2_out : in2_pin;
  always_comb begin
    s1_nxt = raw;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 2'h0;
      s2_r <= 2'h0;
      s3_r <= 2'h0;
    end else if (ce) begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end
  assign rise = s2_r[0] & ~s3_r[0];
  assign fall = ~s2_r[0] & s3_r[0];
  // tick source: every clock or selected edge
  always_comb begin
    tick_c = 1'b1;
    if (cfg_mode) begin
      case (cfg_pol)
        LPT_POL_RISE: tick_c = rise;
        LPT_POL_FALL: tick_c = fall;
        LPT_POL_BOTH: tick_c = rise | fall;
        default: tick_c = rise;
      endcase
    end
  end
  assign tk.tick = tick_c & ~in2_mux | tick_c & in2_mux;
  assign tk.in1_lvl = s2_r[0];
  assign tk.trig_lvl = s2_r[1];
endmodule

// ### src/lpt_ext_counter.sv
// counter clocked straight by input one in external clock mode
`timescale 1ns/10ps
module lpt_ext_counter
  import lpt_pkg::*;
(
  // link clock from input one
  input wire logic ext_clk,
  input wire logic rst_n,
  input wire logic run,
  // count out, gray coded for the crossing
  output logic [CNT_W-1:0] gray_cnt
);
  import lpt_pkg::*;
  logic [2:0] drop_r, drop_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] g_r, g_nxt;
  always_comb begin
    drop_nxt = drop_r;
    cnt_nxt = cnt_r;
    if (!run) begin
      // disable clears; needs an input edge to land
      drop_nxt = 3'h0;
      cnt_nxt = 16'h0000;
    end else if (drop_r != EXT_DROP) begin
      drop_nxt = drop_r + 3'h1;
    end else begin
      cnt_nxt = cnt_r + 16'h0001;
    end
    g_nxt = cnt_nxt ^ (cnt_nxt >> 1);
  end
  // kernel clocked by one chosen edge only
  always_ff @(posedge ext_clk or negedge rst_n) begin
    if (!rst_n) begin
      drop_r <= 3'h0;
      cnt_r <= 16'h0000;
      g_r <= 16'h0000;
    end else begin
      drop_r <= drop_nxt;
      cnt_r <= cnt_nxt;
      g_r <= g_nxt;
    end
  end
  assign gray_cnt = g_r;
endmodule

// ### src/lpt_top.sv
// low-power timer clock and input front end with counter and registers
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module lpt_top
  import lpt_pkg::*;
#(
  parameter bit HAS_EXT = 1'b1
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // pins and internal inputs
  input wire logic in1_pin,
  input wire logic in2_pin,
  input wire logic trigger_pin,
  input wire logic rtc_alarm,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  // outputs
  output logic waveform_output,
  output logic wake_event_out,
  output logic timer_interrupt_out,
  output logic compare_match_dma_req,
  output logic reload_match_dma_req
);
  import lpt_pkg::*;
  logic rs1_r, rs2_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end
  wire rst_n = rs2_r;

  logic en_r, en_nxt;
  logic [15:0] cfg_r, cfg_nxt;
  logic [CNT_W-1:0] arr_r, arr_nxt, cmp_r, cmp_nxt;
  logic [ST_W-1:0] st_r, st_nxt, mask_r, mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  lpt_state_t state_r, state_nxt;
  logic [1:0] dly_r, dly_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [PSC_W-1:0] psc_r, psc_nxt;
  logic wave_r, wave_nxt, irq_r, irq_nxt, wake_r, wake_nxt;
  logic dcm_r, dcm_nxt, dar_r, dar_nxt;
  logic trg_d_r, trg_d_nxt;
  logic [7:0] trig_raw;
  logic ext_mode, cnt_tick, trig_edge, ev_cmp, ev_arr;
  logic [1:0] ksrc;

  lpt_tick_if tk ();
  assign trig_raw = {cmp2_out, cmp1_out, 4'h0, rtc_alarm, trigger_pin};

  lpt_input_front u_front (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .cfg_mode(cfg_r[CFG_MODE]),
    .cfg_pol(cfg_r[CFG_POL +: 2]),
    .in1_sel(cfg_r[CFG_IN1S]),
    .in2_sel(cfg_r[CFG_IN2S]),
    .trig_sel(cfg_r[CFG_TSEL +: 3]),
    .in1_pin(in1_pin),
    .in2_pin(in2_pin),
    .cmp1_out(cmp1_out),
    .cmp2_out(cmp2_out),
    .trig_raw(trig_raw),
    .tk(tk.src)
  );

  // external clock path only on the first instance
  assign ext_mode = HAS_EXT & cfg_r[CFG_CLOCK_SOURCE_SELECT];
  // kernel source field; clock muxing is outside, field visible
  assign ksrc = cfg_r[CFG_KSRC +: 2];
  // external counter runs on in1 edge; falling polarity inverts clock
  logic ext_clk;
  logic [CNT_W-1:0] ext_gray;
  assign ext_clk = in1_pin ^ cfg_r[CFG_POL];
  lpt_ext_counter u_ext (
    .ext_clk(ext_clk),
    .rst_n(rst_n),
    .run(ext_mode & en_r),
    .gray_cnt(ext_gray)
  );
  // gray count crossed through two flops
  logic [CNT_W-1:0] xg1_r, xg2_r, ext_bin;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xg1_r <= 16'h0000;
      xg2_r <= 16'h0000;
    end else if (ce) begin
      xg1_r <= ext_gray;
      xg2_r <= xg1_r;
    end
  end
  always_comb begin
    ext_bin[CNT_W-1] = xg2_r[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      ext_bin[i] = ext_bin[i+1] ^ xg2_r[i];
    end
  end

  assign trig_edge = tk.trig_lvl & ~trg_d_r;
  // prescaler 2^psc for psc 0 to 3, 8 for psc 4 to 7 (3-bit psc_r), then counter
  // matches only while running, else idle zeros would raise flags
  assign cnt_tick = (state_r == LPT_ST_RUN) && en_r && tk.tick
    && (psc_r == PSC_W'((1 << cfg_r[CFG_PSC +: 3]) - 1));
  assign ev_cmp = cnt_tick && (cnt_r == cmp_r);
  assign ev_arr = cnt_tick && (cnt_r == arr_r);

  always_comb begin
    en_nxt = en_r;
    cfg_nxt = cfg_r;
    arr_nxt = arr_r;
    cmp_nxt = cmp_r;
    mask_nxt = mask_r;
    st_nxt = st_r;
    rdata_nxt = 32'h0;
    if (wr) begin
      case (addr)
        REG_CTRL: en_nxt = wdata[0];
        REG_CFG: cfg_nxt = en_r ? cfg_r : wdata[15:0];
        REG_ARR: arr_nxt = wdata[15:0];
        REG_CMP: cmp_nxt = wdata[15:0];
        REG_MASK: mask_nxt = wdata[ST_W-1:0];
        REG_STAT: st_nxt = st_r & ~wdata[ST_W-1:0];
        default: ;
      endcase
    end
    // set wins over clear
    st_nxt[ST_CMPM] = st_nxt[ST_CMPM] | ev_cmp;
    st_nxt[ST_ARRM] = st_nxt[ST_ARRM] | ev_arr;
    if (rd) begin
      case (addr)
        REG_CTRL: rdata_nxt = {28'h0, ksrc, state_r};
        REG_CFG: rdata_nxt = {16'h0, cfg_r};
        REG_ARR: rdata_nxt = {16'h0, arr_r};
        REG_CMP: rdata_nxt = {16'h0, cmp_r};
        REG_CNT: rdata_nxt = {16'h0, ext_mode ? ext_bin : cnt_r};
        REG_STAT: rdata_nxt = {30'h0, st_r};
        REG_MASK: rdata_nxt = {30'h0, mask_r};
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  // enable after two counter clocks, disable clears after three
  always_comb begin
    state_nxt = state_r;
    dly_nxt = dly_r;
    cnt_nxt = cnt_r;
    psc_nxt = psc_r;
    trg_d_nxt = tk.trig_lvl;
    case (state_r)
      LPT_ST_OFF: begin
        if (en_r) begin
          state_nxt = LPT_ST_ARM;
          dly_nxt = 2'h0;
        end
      end
      LPT_ST_ARM: begin
        if (!en_r) begin
          state_nxt = LPT_ST_STOP;
          dly_nxt = 2'h0;
        end else begin
          // kernel clocks; edge modes do not count edges that arrive while arming
          dly_nxt = dly_r + 2'h1;
          if (dly_r + 2'h1 == EN_DLY) state_nxt = LPT_ST_RUN;
        end
      end
      LPT_ST_RUN: begin
        if (!en_r) begin
          state_nxt = LPT_ST_STOP;
          dly_nxt = 2'h0;
        end else if (tk.tick) begin
          psc_nxt = cnt_tick ? '0 : psc_r + 3'h1;
          if (cnt_tick) cnt_nxt = (cnt_r == arr_r) ? 16'h0000 : cnt_r + 16'h0001;
        end
      end
      LPT_ST_STOP: begin
        // start attempts ignored here
        dly_nxt = dly_r + 2'h1;
        if (dly_r + 2'h1 == DIS_DLY) begin
          cnt_nxt = 16'h0000;
          psc_nxt = '0;
          state_nxt = LPT_ST_OFF;
        end
      end
      default: state_nxt = LPT_ST_OFF;
    endcase
  end

  always_comb begin
    wave_nxt = (cnt_r < cmp_r) ? cfg_r[CFG_WPOL] : ~cfg_r[CFG_WPOL];
    irq_nxt = |(st_nxt & mask_r);
    wake_nxt = |(st_nxt & mask_r) | (trig_edge & cfg_r[CFG_TEN]);
    dcm_nxt = ev_cmp;
    dar_nxt = ev_arr;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= 1'b0;
      cfg_r <= 16'h0000;
      arr_r <= ARR_RST;
      cmp_r <= CMP_RST;
      mask_r <= '0;
      st_r <= '0;
      rdata_r <= 32'h0;
      state_r <= LPT_ST_OFF;
      dly_r <= 2'h0;
      cnt_r <= 16'h0000;
      psc_r <= '0;
      trg_d_r <= 1'b0;
      wave_r <= 1'b0;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
      dcm_r <= 1'b0;
      dar_r <= 1'b0;
    end else if (ce) begin
      en_r <= en_nxt;
      cfg_r <= cfg_nxt;
      arr_r <= arr_nxt;
      cmp_r <= cmp_nxt;
      mask_r <= mask_nxt;
      st_r <= st_nxt;
      rdata_r <= rdata_nxt;
      state_r <= state_nxt;
      dly_r <= dly_nxt;
      cnt_r <= cnt_nxt;
      psc_r <= psc_nxt;
      trg_d_r <= trg_d_nxt;
      wave_r <= wave_nxt;
      irq_r <= irq_nxt;
      wake_r <= wake_nxt;
      dcm_r <= dcm_nxt;
      dar_r <= dar_nxt;
    end
  end
  assign rdata = rdata_r;
  assign waveform_output = wave_r;
  assign timer_interrupt_out = irq_r;
  assign wake_event_out = wake_r;
  assign compare_match_dma_req = dcm_r;
  assign reload_match_dma_req = dar_r;

  // disable clears counter three cycles later
  AST_DIS_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (ce throughout (state_r == LPT_ST_RUN && !en_r) ##1 1'b1 ##2 1'b1)
    |=> (cnt_r == 16'h0000)) else $error("counter not cleared after disable");
  AST_DMA_CMP: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && ev_cmp) |=> compare_match_dma_req) else $error("compare dma missing");
  AST_DMA_ARR: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && ev_arr) |=> reload_match_dma_req) else $error("reload dma missing");
  AST_CNT_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && ev_arr && state_r == LPT_ST_RUN && en_r) |=> (cnt_r == 16'h0000))
    else $error("counter did not wrap");
  AST_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> (timer_interrupt_out == |(st_r & $past(mask_r))))
    else $error("interrupt level wrong");
  // internal mode, psc 0: counts every clock while running
  AST_INT_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && state_r == LPT_ST_RUN && en_r && !cfg_r[CFG_MODE] && cfg_r[6:4] == 3'h0
     && cnt_r != arr_r) |=> (cnt_r == $past(cnt_r) + 16'h0001))
    else $error("internal count missed");
  AST_EN_DLY: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && state_r == LPT_ST_OFF && en_r) |=> (state_r == LPT_ST_ARM))
    else $error("enable not armed");
  // edge mode without edge gives no count
  AST_EDGE_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && cfg_r[CFG_MODE] && !tk.tick) |=> (cnt_r == $past(cnt_r) || state_r != LPT_ST_RUN))
    else $error("count without edge");
endmodule

// ### tb/lpt_pins_model.sv
// model of the pins, comparators and alarm that feed the timer
`timescale 1ns/10ps
module lpt_pins_model (
  // clock
  input wire logic clk,
  // levels to the timer
  output logic in1_pin,
  output logic in2_pin,
  output logic trigger_pin,
  output logic rtc_alarm,
  output logic cmp1_out,
  output logic cmp2_out
);
  logic [5:0] lvl;
  assign {cmp2_out, cmp1_out, rtc_alarm, trigger_pin, in2_pin, in1_pin} = lvl;
  initial lvl = 6'h00;
  // slow edges
  // gap of 6 keeps edges over four kernel clocks apart
  task automatic pulse(input int src, input int n, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge clk);
      lvl[src] <= 1'b1;
      repeat (gap) @(posedge clk);
      lvl[src] <= 1'b0;
    end
  endtask
endmodule

// ### tb/low_power_timer_clock_and_inputs_test.sv
// self-checking bench for the timer front end
`timescale 1ns/10ps
module low_power_timer_clock_and_inputs_test;
  import lpt_pkg::*;
  logic clk, resetn, ce, wr, rd;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  logic in1_pin, in2_pin, trigger_pin, rtc_alarm, cmp1_out, cmp2_out;
  logic waveform_output, wake_event_out, timer_interrupt_out;
  logic compare_match_dma_req, reload_match_dma_req;
  logic wake_seen, cdma_seen, adma_seen;
  int errors, checked, cycles;
  int srcs [4] = '{2, 3, 4, 5};
  int tsels [4] = '{0, 1, 6, 7};

  lpt_top #(.HAS_EXT(1'b1)) i_lpt_top (
    .clk(clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .in1_pin(in1_pin), .in2_pin(in2_pin), .trigger_pin(trigger_pin),
    .rtc_alarm(rtc_alarm), .cmp1_out(cmp1_out), .cmp2_out(cmp2_out),
    .waveform_output(waveform_output), .wake_event_out(wake_event_out),
    .timer_interrupt_out(timer_interrupt_out),
    .compare_match_dma_req(compare_match_dma_req),
    .reload_match_dma_req(reload_match_dma_req)
  );
  lpt_pins_model i_lpt_pins_model (
    .clk(clk), .in1_pin(in1_pin), .in2_pin(in2_pin), .trigger_pin(trigger_pin),
    .rtc_alarm(rtc_alarm), .cmp1_out(cmp1_out), .cmp2_out(cmp2_out)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // one-cycle outputs are caught here; also the hang limit
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (wake_event_out === 1'b1) wake_seen <= 1'b1;
    if (compare_match_dma_req === 1'b1) cdma_seen <= 1'b1;
    if (reload_match_dma_req === 1'b1) adma_seen <= 1'b1;
    if (cycles == 20000) begin
      errors++;
      $display("MISMATCH run length expected below 20000 seen %0d", cycles);
      test_done();
    end
  end

  function automatic logic [31:0] fld(input int pos, input int v);
    return 32'(v) << pos;
  endfunction

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
    logic [31:0] got;
    rd_reg(a, got);
    chk(what, exp, got);
  endtask

  initial begin
    int p;
    logic [31:0] c0, c1;
    errors = 0;
    checked = 0;
    cycles = 0;
    resetn = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(REG_ARR, {16'h0000, ARR_RST}, "arr reset");
    rd_chk(REG_CMP, 32'h0, "cmp reset");
    rd_chk(4'hf, 32'h0, "unmapped read");
    wr_reg(REG_CFG, fld(CFG_KSRC, 2));
    rd_chk(REG_CTRL, 32'h8, "kernel source field");
    chk("irq reset", 32'h0, {31'h0, timer_interrupt_out});
    $display("test reset done");
    for (p = 0; p < 4; p++) begin
      wr_reg(REG_CFG, fld(CFG_PSC, p));
      wr_reg(REG_CTRL, 32'h1);
      repeat (8) @(posedge clk);
      rd_reg(REG_CNT, c0);
      repeat (38) @(posedge clk);
      rd_reg(REG_CNT, c1);
      chk("prescaled count", 32'(40 >> p), c1 - c0);
      if (p == 3) begin
        wr_reg(REG_CFG, 32'h0);
        rd_chk(REG_CFG, fld(CFG_PSC, 3), "cfg held while enabled");
      end
      wr_reg(REG_CTRL, 32'h0);
      repeat (4) @(posedge clk);
      rd_chk(REG_CNT, 32'h0, "count cleared on disable");
    end
    $display("test kernel clock done");
    // last pass counts comparator one with the pin toggling too
    for (p = 0; p < 4; p++) begin
      wr_reg(REG_CFG, fld(CFG_MODE, 1) | fld(CFG_POL, p % 3) | fld(CFG_IN1S, p / 3));
      wr_reg(REG_CTRL, 32'h1);
      repeat (8) @(posedge clk);
      i_lpt_pins_model.pulse(p / 3 * 4, 3, 6);
      if (p == 3) i_lpt_pins_model.pulse(0, 2, 6);
      repeat (8) @(posedge clk);
      rd_chk(REG_CNT, (p == 2) ? 32'h6 : 32'h3, "edge count");
      wr_reg(REG_CTRL, 32'h0);
      repeat (4) @(posedge clk);
    end
    $display("test edge count done");
    wr_reg(REG_CFG, fld(CFG_CLOCK_SOURCE_SELECT, 1) | fld(CFG_MODE, 1) | fld(CFG_POL, LPT_POL_BOTH));
    wr_reg(REG_CTRL, 32'h1);
    repeat (8) @(posedge clk);
    i_lpt_pins_model.pulse(0, 4, 6);
    repeat (12) @(posedge clk);
    rd_chk(REG_CNT, 32'h0, "first edges lost");
    i_lpt_pins_model.pulse(0, 5, 6);
    repeat (12) @(posedge clk);
    rd_chk(REG_CNT, 32'h5, "external rising count");
    wr_reg(REG_CTRL, 32'h0);
    // the external kernel needs edges to see the disable
    i_lpt_pins_model.pulse(0, 3, 6);
    repeat (4) @(posedge clk);
    rd_chk(REG_CNT, 32'h0, "external count cleared");
    $display("test external clock done");
    wr_reg(REG_ARR, 32'd20);
    wr_reg(REG_CMP, 32'd10);
    wr_reg(REG_MASK, 32'h0);
    wr_reg(REG_STAT, 32'h3);
    wr_reg(REG_CFG, fld(CFG_WPOL, 1));
    cdma_seen = 1'b0;
    adma_seen = 1'b0;
    wr_reg(REG_CTRL, 32'h1);
    repeat (60) @(posedge clk);
    wr_reg(REG_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    chk("dma pulses", 32'h3, {30'h0, adma_seen, cdma_seen});
    chk("masked irq", 32'h0, {31'h0, timer_interrupt_out});
    rd_chk(REG_STAT, 32'h3, "match flags");
    wr_reg(REG_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq and wake", 32'h3, {30'h0, wake_event_out, timer_interrupt_out});
    chk("waveform below compare", 32'h1, {31'h0, waveform_output});
    wr_reg(REG_STAT, 32'h1);
    repeat (2) @(posedge clk);
    rd_chk(REG_STAT, 32'h2, "compare flag cleared");
    chk("irq after clear", 32'h0, {31'h0, timer_interrupt_out});
    $display("test match events done");
    wr_reg(REG_MASK, 32'h0);
    for (p = 0; p < 4; p++) begin
      wr_reg(REG_CFG, fld(CFG_TEN, 1) | fld(CFG_TSEL, tsels[p]));
      wr_reg(REG_CTRL, 32'h1);
      repeat (6) @(posedge clk);
      wake_seen = 1'b0;
      i_lpt_pins_model.pulse(srcs[(p + 1) % 4], 1, 6);
      repeat (6) @(posedge clk);
      chk("unselected trigger", 32'h0, {31'h0, wake_seen});
      i_lpt_pins_model.pulse(srcs[p], 1, 6);
      repeat (6) @(posedge clk);
      chk("selected trigger", 32'h1, {31'h0, wake_seen});
      wr_reg(REG_CTRL, 32'h0);
      repeat (4) @(posedge clk);
    end
    $display("test trigger select done");
    test_done();
  end
endmodule
